// ===== dv/button_model.sv
// Push-button contact model with bounce and on-chip pull-up
`default_nettype none
module button_model (
    input wire logic ref_clk,
    input wire logic press,
    output logic pin_n = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    int n = 0;
    always @(posedge ref_clk)
    begin
        n <= press ? n + 1 : 0;
        // Bounce on closing; open contact goes to the pull-up level
        pin_n <= !press || (n < 3 && n[0]);
    end
endmodule // button_model
`default_nettype wire

// ===== dv/wiper_step_control_bench.sv
// Self-checking bench for the wiper step control
`default_nettype none
module wiper_step_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, srst = 1, up = 0, dn = 0, st = 0, supply_fail = 0, d, ce = 1;
    logic up_n, dn_n, st_n, wiper_stable, store_write, scan_fast;
    logic [4:0] stored_wiper = 0, wiper, store_data, exp;
    int err_total = 0, checked = 0, seed = 32'hed4f138e;
    always #4 ref_clk = ~ref_clk;
    button_model u_up (.ref_clk(ref_clk), .press(up), .pin_n(up_n));
    button_model u_dn (.ref_clk(ref_clk), .press(dn), .pin_n(dn_n));
    button_model u_st (.ref_clk(ref_clk), .press(st), .pin_n(st_n));
    wiper_step_control #(.DEBOUNCE_CYCLES(8), .SLOW_STEP_CYCLES(20), .FAST_STEP_CYCLES(5),
        .SLOW_SCAN_CYCLES(60), .SETTLE_CYCLES(10)) u_wiper_step_control (.ref_clk(ref_clk),
        .srst(srst), .clk_en(ce), .step_up_button_n(up_n), .step_down_button_n(dn_n),
        .store_enable_input_n(st_n), .supply_fail(supply_fail), .stored_wiper(stored_wiper),
        .wiper(wiper), .wiper_stable(wiper_stable), .store_write(store_write),
        .store_data(store_data), .scan_fast(scan_fast));
    function automatic logic [4:0] nxt(input logic [4:0] w, input logic u);
        return u ? (w == 5'h1f ? w : w + 5'h01) : (w == 5'h00 ? w : w - 5'h01);
    endfunction
    task automatic cmp(input logic [4:0] seen, input logic [4:0] want);
        checked++;
        if (seen !== want)
        begin
            err_total++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic go(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic hold(input logic u, input int n);
        up = u;
        dn = !u;
        go(n);
        up = 0;
        dn = 0;
        // Let the release reach idle so a repeat is a fresh press
        go(6);
    endtask
    task automatic boot(input logic auto_mode);
        srst = 1;
        st = auto_mode;
        stored_wiper = 5'($random(seed));
        go(3);
        srst = 0;
        go(16);
        cmp(wiper, stored_wiper);
    endtask
    task automatic test_done;
        if (err_total == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        go(5000);
        err_total++;
        test_done();
    end
    initial
    begin
        boot(0);
        hold(1, 300);
        go(4);
        cmp(wiper, 5'h1f);
        dn = 1;
        go(150);
        cmp(scan_fast, 1'b1);
        go(150);
        dn = 0;
        go(8);
        cmp(scan_fast, 1'b0);
        cmp(wiper, 5'h00);
        // No idle gap between a down press and the next up press
        dn = 1;
        go(40);
        dn = 0;
        up = 1;
        go(40);
        up = 0;
        go(4);
        cmp(wiper, nxt(5'h00, 1));
        hold(1, 5);
        go(4);
        cmp(wiper, 5'h01);
        exp = 5'h01;
        // Press length fits exactly one slow step
        repeat (6)
        begin
            d = 1'($random(seed));
            hold(d, 40 + ($random(seed) & 7));
            exp = nxt(exp, d);
        end
        go(4);
        cmp(wiper, exp);
        // Frozen clock enable: a long press must not be counted
        ce = 0;
        up = 1;
        go(60);
        cmp(wiper, exp);
        up = 0;
        go(6);
        ce = 1;
        go(6);
        st = 1;
        go(15);
        st = 0;
        go(8);
        cmp(store_data, exp);
        boot(1);
        supply_fail = 1;
        go(8);
        supply_fail = 0;
        cmp(store_data, stored_wiper);
        test_done();
    end
endmodule // wiper_step_control_bench
`default_nettype wire

// ===== dv/wiper_step_control_props.sv
// Port assertions for the wiper step control
`default_nettype none
module wiper_step_control_props (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic step_up_button_n,
    input wire logic [4:0] wiper,
    input wire logic wiper_stable,
    input wire logic store_write,
    input wire logic [4:0] store_data,
    input wire logic scan_fast,
    input wire logic step_down_button_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence s_settle;
        ##[1:14] wiper_stable;
    endsequence
    logic was;
    assign was = wiper_stable;
    a_settle_bound: assert property ($fell(srst) |-> s_settle) else $error("slow recall");
    a_stable_hold: assert property (was |=> was) else $error("stable fell");
    a_top_saturate: assert property ($past(wiper) == 5'h1f && $past(was) |-> wiper != 5'h00)
        else $error("wrap at top");
    a_bottom_saturate: assert property ($past(wiper) == 5'h00 && $past(was) |-> wiper != 5'h1f)
        else $error("wrap at bottom");
    a_up_cause: assert property (was && $past(was) && wiper > $past(wiper)
        |-> !$past(step_up_button_n, 10)) else $error("step without press");
    a_step_single: assert property (was && $past(was) && wiper != $past(wiper)
        |-> wiper - $past(wiper) == 5'h01 || $past(wiper) - wiper == 5'h01) else $error("big step");
    a_fast_release: assert property (scan_fast && step_up_button_n && step_down_button_n
        |-> ##[0:6] !scan_fast) else $error("fast after release");
    a_store_pulse: assert property (store_write |-> store_data == wiper ##1 !store_write)
        else $error("bad store");
endmodule // wiper_step_control_props
bind wiper_step_control wiper_step_control_props u_props (.*);
`default_nettype wire

// ===== verilog/wiper_step_control.v
// Push-button wiper step control with debounce, scan modes and store/recall
`include "wiper_step_map.vh"
`default_nettype none
module wiper_step_control #(
    parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
    parameter SLOW_STEP_CYCLES = `SLOW_STEP_CYCLES,
    parameter FAST_STEP_CYCLES = `FAST_STEP_CYCLES,
    parameter SLOW_SCAN_CYCLES = `SLOW_SCAN_CYCLES,
    parameter SETTLE_CYCLES = `POWERUP_SETTLE_CYCLES,
    parameter TAP_BITS = `TAP_BITS
) (
    input wire ref_clk,
    input wire srst,
    input wire clk_en,
    input wire step_up_button_n,
    input wire step_down_button_n,
    input wire store_enable_input_n,
    input wire supply_fail,
    input wire [TAP_BITS-1:0] stored_wiper,
    output reg [TAP_BITS-1:0] wiper,
    output reg wiper_stable,
    output reg store_write,
    output reg [TAP_BITS-1:0] store_data,
    output reg scan_fast
);
    localparam ST_RECALL = 4'h1;
    localparam ST_IDLE = 4'h2;
    localparam ST_SLOW = 4'h4;
    localparam ST_FAST = 4'h8;

    // Two-stage synchronisers; index 0 up, 1 down, 2 store, 3 supply fail
    reg [3:0] sync_a;
    reg [3:0] sync_b;
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            sync_a <= 4'hf;
            sync_b <= 4'hf;
        end
        else if (clk_en)
        begin
            sync_a <= {~supply_fail, store_enable_input_n, step_down_button_n,
                step_up_button_n};
            sync_b <= sync_a;
        end
    end

    // Debounce: a line counts as low once it has been low for the whole window
    wire [2:0] db_low;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_db
            reg [31:0] cnt;
            reg low;
            always @(posedge ref_clk)
            begin
                if (srst)
                begin
                    cnt <= 32'h0;
                    low <= 1'b0;
                end
                else if (clk_en)
                begin
                    if (sync_b[g])
                    begin
                        cnt <= 32'h0;
                        low <= 1'b0;
                    end
                    else if (cnt >= DEBOUNCE_CYCLES - 1)
                        low <= 1'b1;
                    else
                        cnt <= cnt + 32'h1;
                end
            end
            assign db_low[g] = low;
        end
    endgenerate

    wire up_held = db_low[0] & ~db_low[1];
    wire down_held = db_low[1] & ~db_low[0];
    wire press = up_held | down_held;
    wire fail = ~sync_b[3];

    // Auto store is chosen by the store line level seen when recall ends
    reg auto_mode;
    reg store_low_seen;
    reg fail_done;
    reg [3:0] state;
    reg [31:0] step_cnt;
    reg [31:0] hold_cnt;
    // Only a manual store press locks stepping; a strapped auto store line must not
    wire store_lock = db_low[2] & ~auto_mode;
    // Step period follows the scan mode held in state
    wire [31:0] step_limit = (state == ST_FAST) ? FAST_STEP_CYCLES - 1 : SLOW_STEP_CYCLES - 1;

    // Saturating neighbour taps; the ends hold rather than wrap
    reg [TAP_BITS-1:0] next_wiper_up;
    reg [TAP_BITS-1:0] next_wiper_down;
    always @*
    begin
        next_wiper_up = wiper;
        next_wiper_down = wiper;
        if (wiper != `TAP_TOP)
        begin
            next_wiper_up = wiper + {{(TAP_BITS-1){1'b0}}, 1'b1};
        end
        if (wiper != `TAP_BOTTOM)
        begin
            next_wiper_down = wiper - {{(TAP_BITS-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            state <= ST_RECALL;
            wiper <= `TAP_BOTTOM;
            wiper_stable <= 1'b0;
            step_cnt <= 32'h0;
            hold_cnt <= 32'h0;
            scan_fast <= 1'b0;
            auto_mode <= 1'b0;
            store_low_seen <= 1'b0;
            fail_done <= 1'b0;
            store_write <= 1'b0;
            store_data <= `TAP_BOTTOM;
        end
        else if (clk_en)
        begin
            store_write <= 1'b0;
            case (state)
                ST_RECALL:
                begin
                    wiper <= stored_wiper;
                    if (step_cnt >= SETTLE_CYCLES - 1)
                    begin
                        state <= ST_IDLE;
                        wiper_stable <= 1'b1;
                        // Synchronised level: the debounce window outlasts recall
                        auto_mode <= ~sync_b[2];
                        step_cnt <= 32'h0;
                    end
                    else
                    begin
                        step_cnt <= step_cnt + 32'h1;
                    end
                end
                ST_IDLE:
                begin
                    scan_fast <= 1'b0;
                    hold_cnt <= 32'h0;
                    step_cnt <= 32'h0;
                    // Store line taken low in manual store mode locks out stepping
                    if (press && !store_lock)
                    begin
                        state <= ST_SLOW;
                    end
                end
                ST_SLOW, ST_FAST:
                begin
                    if (!press || store_lock)
                    begin
                        state <= ST_IDLE;
                    end
                    else
                    begin
                        if (hold_cnt < SLOW_SCAN_CYCLES)
                        begin
                            hold_cnt <= hold_cnt + 32'h1;
                        end
                        else
                        begin
                            state <= ST_FAST;
                            scan_fast <= 1'b1;
                        end
                        if (step_cnt >= step_limit)
                        begin
                            step_cnt <= 32'h0;
                            if (up_held)
                                wiper <= next_wiper_up;
                            else if (down_held)
                                wiper <= next_wiper_down;
                        end
                        else
                        begin
                            step_cnt <= step_cnt + 32'h1;
                        end
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase

            // Store paths; wiper only read after recall so stale values never land
            if (state != ST_RECALL)
            begin
                if (auto_mode && db_low[2] && fail && !fail_done)
                begin
                    store_write <= 1'b1;
                    store_data <= wiper;
                    fail_done <= 1'b1;
                end
                if (!fail)
                    fail_done <= 1'b0;
                if (!auto_mode)
                begin
                    if (db_low[2])
                        store_low_seen <= 1'b1;
                    else if (store_low_seen)
                    begin
                        store_low_seen <= 1'b0;
                        store_write <= 1'b1;
                        store_data <= wiper;
                    end
                end
            end
        end
    end
endmodule // wiper_step_control
`default_nettype wire

// ===== verilog/wiper_step_map.vh
// Timing and layout constants for the push-button wiper step control
`ifndef WIPER_STEP_MAP_VH
`define WIPER_STEP_MAP_VH
`define CLK_PERIOD_NS 8
`define DEBOUNCE_MS 20
`define SLOW_STEP_MS 250
`define FAST_STEP_MS 50
`define SLOW_SCAN_MS 1000
`define POWERUP_SETTLE_US 500
`define NS_PER_MS 1000000
`define NS_PER_US 1000
`define DEBOUNCE_CYCLES (`DEBOUNCE_MS * `NS_PER_MS / `CLK_PERIOD_NS)
`define SLOW_STEP_CYCLES (`SLOW_STEP_MS * `NS_PER_MS / `CLK_PERIOD_NS)
`define FAST_STEP_CYCLES (`FAST_STEP_MS * `NS_PER_MS / `CLK_PERIOD_NS)
`define SLOW_SCAN_CYCLES (`SLOW_SCAN_MS * `NS_PER_MS / `CLK_PERIOD_NS)
`define POWERUP_SETTLE_CYCLES (`POWERUP_SETTLE_US * `NS_PER_US / `CLK_PERIOD_NS)
`define TAP_BITS 5
`define TAP_BOTTOM 5'h00
`define TAP_TOP 5'h1f
`endif
